//--- line_ctrl_pkg.sv
// line_ctrl_pkg: constants for the line control and ring detect block
// assumes a 250 MHz device clock and a 9600 Hz sample tick
package line_ctrl_pkg;
	// register offsets (byte addresses, word wide)
	localparam logic [7:0] ADDR_TERM_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_RING_CTRL   = 8'h04;
	localparam logic [7:0] ADDR_RING_STATUS = 8'h08;
	localparam logic [7:0] ADDR_THRESH      = 8'h0C;
	// term_ctrl fields
	localparam int TERM_RING_THR_BIT  = 0;
	localparam int TERM_RINGER_Z_BIT  = 1;
	localparam int TERM_DC_LSB        = 2;
	localparam int TERM_AC_BIT        = 4;
	localparam int TERM_OHS_BIT       = 5;
	localparam int TERM_FORCE_LV_BIT  = 6;
	// ring_ctrl fields
	localparam int RING_FULL_WAVE_BIT = 0;
	// ring_status fields
	localparam int STAT_POS_BIT       = 0;
	localparam int STAT_NEG_BIT       = 1;
	localparam int STAT_ONE_SHOT_BIT  = 2;
	// dc termination codes
	localparam logic [1:0] DC_LOW_REGION = 2'h0;
	localparam logic [1:0] DC_LOW_VOLT   = 2'h1;
	localparam logic [1:0] DC_STANDARD   = 2'h2;
	localparam logic [1:0] DC_CUR_LIMIT  = 2'h3;
	localparam logic [1:0] DC_RESET      = DC_STANDARD;
	// threshold reset values (signed ring sample units)
	localparam logic [15:0] THR_LOW_RESET  = 16'h0800;
	localparam logic [15:0] THR_HIGH_RESET = 16'h1000;
	// timing
	localparam int CLK_HZ          = 250_000_000;
	localparam int SAMPLE_HZ       = 9600;
	localparam int SAMPLE_DIV      = CLK_HZ / SAMPLE_HZ;
	localparam int ONE_SHOT_SAMPLES = 65536;
	// transmit gain codes: 1.7 dB reduction as a Q1.15 scale, unity otherwise
	localparam logic [15:0] TX_GAIN_UNITY = 16'h7FFF;
	localparam logic [15:0] TX_GAIN_LV    = 16'h693E;
endpackage

//--- sample_tick.sv
// sample_tick: one-cycle pulse at the sample rate
// assumes a free-running device clock
`timescale 1ns/1ps
`default_nettype none
module sample_tick #(
	parameter int DIV = 26041
) (
	input  wire logic mclk_in,
	input  wire logic resetn_in,
	output logic      tick_out
);
	if (DIV < 2) begin
		$error("sample_tick: DIV too small");
	end

	typedef struct packed {
		logic [31:0] cnt;
		logic        tick;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (st_r.cnt == 32'(DIV - 1)) begin
			st_nxt.cnt  = 32'h0;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.cnt = st_r.cnt + 32'h1;
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tick_out = st_r.tick;
endmodule
`default_nettype wire

//--- ring_one_shot.sv
// ring_one_shot: retriggerable ring-detect one-shot
// assumes tick_in is one cycle per sample and trig_in is sampled on it
`timescale 1ns/1ps
`default_nettype none
module ring_one_shot #(
	parameter int SAMPLES = 65536
) (
	input  wire logic mclk_in,
	input  wire logic resetn_in,
	input  wire logic tick_in,
	input  wire logic trig_in,
	input  wire logic clear_in,
	output logic      active_out
);
	if (SAMPLES < 1) begin
		$error("ring_one_shot: SAMPLES must be positive");
	end

	typedef struct packed {
		logic [31:0] cnt;
		logic        active;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (clear_in) begin
			st_nxt = '0;
		end else if (tick_in) begin
			if (trig_in) begin
				st_nxt.cnt    = 32'(SAMPLES);
				st_nxt.active = 1'b1;
			end else if (st_r.cnt != 32'h0) begin
				st_nxt.cnt    = st_r.cnt - 32'h1;
				st_nxt.active = (st_r.cnt != 32'h1);
			end
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign active_out = st_r.active;
endmodule
`default_nettype wire

//--- line_ctrl.sv
// line_ctrl: line termination control and manual ring detector
// assumes ring samples and off-hook come from another domain; bus on mclk_in
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module line_ctrl #(
	parameter int SAMPLE_DIV = line_ctrl_pkg::SAMPLE_DIV,
	parameter int ONE_SHOT   = line_ctrl_pkg::ONE_SHOT_SAMPLES,
	parameter int RING_W     = 16
) (
	// clock and reset
	input  wire logic              mclk_in,
	input  wire logic              resetn_in,
	// register port
	input  wire logic [7:0]        addr_in,
	input  wire logic [31:0]       wdata_in,
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	output logic      [31:0]       rdata_out,
	// line side inputs
	input  wire logic [RING_W-1:0] ring_in_pos,
	input  wire logic [RING_W-1:0] ring_in_neg,
	input  wire logic              offhook_in,
	// termination controls
	output logic      [1:0]        dc_term_mode_out,
	output logic                   dc_low_volt_out,
	output logic                   ac_term_select_out,
	output logic                   ring_thresh_sel_out,
	output logic                   ringer_imp_reduce_out,
	output logic                   onhook_speed_out,
	output logic      [15:0]       tx_gain_out,
	// ring status
	output logic                   ring_pos_flag_out,
	output logic                   ring_neg_flag_out,
	output logic                   ring_detect_one_shot_out
);
	////////////////////////////////////////////////////////////////////////////////
	// parameter checks

	if (RING_W < 2 || RING_W > 16) begin
		$error("line_ctrl: RING_W must be 2..16");
	end
	if (SAMPLE_DIV < 2) begin
		$error("line_ctrl: SAMPLE_DIV must be at least 2");
	end
	if (ONE_SHOT < 1) begin
		$error("line_ctrl: ONE_SHOT must be positive");
	end

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [1:0]        dc_term_mode;
		logic              force_low_volt_term;
		logic              ac_term_select;
		logic              ring_thresh_sel;
		logic              ringer_imp_reduce;
		logic              onhook_speed;
		logic              ring_full_wave_en;
		logic [15:0]       thr_low;
		logic [15:0]       thr_high;
		logic [RING_W-1:0] pos_s1;
		logic [RING_W-1:0] pos_s2;
		logic [RING_W-1:0] neg_s1;
		logic [RING_W-1:0] neg_s2;
		logic [RING_W-1:0] pos_s3;
		logic [RING_W-1:0] neg_s3;
		logic [RING_W-1:0] pos_q;
		logic [RING_W-1:0] neg_q;
		logic              hook_s1;
		logic              hook_s2;
		logic              hook_d;
		logic              ring_pos_flag;
		logic              ring_neg_flag;
		logic              dc_low_volt;
		logic [15:0]       tx_gain;
		logic [31:0]       rdata;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	logic tick;
	logic one_shot;
	logic offhook_evt;
	logic pos_excursion;
	logic neg_excursion;
	logic signed [RING_W:0] ring_diff;
	logic signed [RING_W:0] thr_pos;
	logic signed [RING_W:0] thr_neg;

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [31:0] term_word(input state_t s);
		logic [31:0] w;
		w = 32'h0;
		w[line_ctrl_pkg::TERM_RING_THR_BIT] = s.ring_thresh_sel;
		w[line_ctrl_pkg::TERM_RINGER_Z_BIT] = s.ringer_imp_reduce;
		w[line_ctrl_pkg::TERM_DC_LSB +: 2]  = s.dc_term_mode;
		w[line_ctrl_pkg::TERM_AC_BIT]       = s.ac_term_select;
		w[line_ctrl_pkg::TERM_OHS_BIT]      = s.onhook_speed;
		w[line_ctrl_pkg::TERM_FORCE_LV_BIT] = s.force_low_volt_term;
		return w;
	endfunction

	// low-voltage termination per dc mode; force only counts in standard mode
	function automatic logic dc_low_volt_of(input logic [1:0] mode, input logic force_lv);
		logic lv;
		lv = 1'b0;
		unique case (mode)
			line_ctrl_pkg::DC_LOW_REGION: begin
				lv = 1'b1;
			end
			line_ctrl_pkg::DC_LOW_VOLT: begin
				lv = 1'b1;
			end
			line_ctrl_pkg::DC_STANDARD: begin
				lv = force_lv;
			end
			line_ctrl_pkg::DC_CUR_LIMIT: begin
				lv = 1'b0;
			end
		endcase
		return lv;
	endfunction

	// transmit reduction only in the selected low-voltage mode
	function automatic logic [15:0] tx_gain_of(input logic [1:0] mode);
		logic [15:0] g;
		g = line_ctrl_pkg::TX_GAIN_UNITY;
		if (mode == line_ctrl_pkg::DC_LOW_VOLT) begin
			g = line_ctrl_pkg::TX_GAIN_LV;
		end
		return g;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// sub-blocks

	sample_tick #(
		.DIV       (SAMPLE_DIV)
	) u_tick (
		.mclk_in   (mclk_in),
		.resetn_in (resetn_in),
		.tick_out  (tick)
	);

	ring_one_shot #(
		.SAMPLES    (ONE_SHOT)
	) u_one_shot (
		.mclk_in    (mclk_in),
		.resetn_in  (resetn_in),
		.tick_in    (tick),
		.trig_in    (pos_excursion),
		.clear_in   (offhook_evt),
		.active_out (one_shot)
	);

	////////////////////////////////////////////////////////////////////////////////
	// ring comparison

	assign ring_diff = $signed({1'b0, st_r.pos_q}) - $signed({1'b0, st_r.neg_q});
	assign thr_pos   = st_r.ring_thresh_sel ?
		$signed({1'b0, st_r.thr_high[RING_W-1:0]}) : $signed({1'b0, st_r.thr_low[RING_W-1:0]});
	assign pos_excursion = ring_diff > thr_pos;
	assign thr_neg       = -thr_pos;
	assign neg_excursion = ring_diff < thr_neg;
	assign offhook_evt   = st_r.hook_s2 && !st_r.hook_d;

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_nxt = st_r;
		st_nxt.pos_s1  = ring_in_pos;
		st_nxt.pos_s2  = st_r.pos_s1;
		st_nxt.neg_s1  = ring_in_neg;
		st_nxt.neg_s2  = st_r.neg_s1;
		st_nxt.hook_s1 = offhook_in;
		st_nxt.hook_s2 = st_r.hook_s1;
		st_nxt.hook_d  = st_r.hook_s2;

		// pin words may be caught mid-change; take one only once two copies agree
		st_nxt.pos_s3  = st_r.pos_s2;
		st_nxt.neg_s3  = st_r.neg_s2;
		if (st_r.pos_s2 == st_r.pos_s3) begin
			st_nxt.pos_q = st_r.pos_s2;
		end
		if (st_r.neg_s2 == st_r.neg_s3) begin
			st_nxt.neg_q = st_r.neg_s2;
		end

		// flags follow the ring difference once per sample; the negative flag only with full-wave enabled
		if (tick) begin
			st_nxt.ring_pos_flag = pos_excursion;
			st_nxt.ring_neg_flag = st_r.ring_full_wave_en && neg_excursion;
		end
		// register writes
		if (wr_in) begin
			unique case (addr_in)
				line_ctrl_pkg::ADDR_TERM_CTRL: begin
					st_nxt.ring_thresh_sel     = wdata_in[line_ctrl_pkg::TERM_RING_THR_BIT];
					st_nxt.ringer_imp_reduce   = wdata_in[line_ctrl_pkg::TERM_RINGER_Z_BIT];
					st_nxt.dc_term_mode        = wdata_in[line_ctrl_pkg::TERM_DC_LSB +: 2];
					st_nxt.ac_term_select      = wdata_in[line_ctrl_pkg::TERM_AC_BIT];
					st_nxt.onhook_speed        = wdata_in[line_ctrl_pkg::TERM_OHS_BIT];
					st_nxt.force_low_volt_term = wdata_in[line_ctrl_pkg::TERM_FORCE_LV_BIT];
				end
				line_ctrl_pkg::ADDR_RING_CTRL: begin
					st_nxt.ring_full_wave_en = wdata_in[line_ctrl_pkg::RING_FULL_WAVE_BIT];
				end
				line_ctrl_pkg::ADDR_THRESH: begin
					st_nxt.thr_low  = wdata_in[15:0];
					st_nxt.thr_high = wdata_in[31:16];
				end
				default: begin
				end
			endcase
		end

		// termination decode from current settings
		st_nxt.dc_low_volt = dc_low_volt_of(st_r.dc_term_mode, st_r.force_low_volt_term);
		st_nxt.tx_gain     = tx_gain_of(st_r.dc_term_mode);

		// reads: data valid the cycle after the strobe
		st_nxt.rdata = 32'h0;
		if (rd_in) begin
			unique case (addr_in)
				line_ctrl_pkg::ADDR_TERM_CTRL: begin
					st_nxt.rdata = term_word(st_r);
				end
				line_ctrl_pkg::ADDR_RING_CTRL: begin
					st_nxt.rdata[line_ctrl_pkg::RING_FULL_WAVE_BIT] = st_r.ring_full_wave_en;
				end
				line_ctrl_pkg::ADDR_RING_STATUS: begin
					st_nxt.rdata[line_ctrl_pkg::STAT_POS_BIT]      = st_r.ring_pos_flag;
					st_nxt.rdata[line_ctrl_pkg::STAT_NEG_BIT]      = st_r.ring_neg_flag;
					st_nxt.rdata[line_ctrl_pkg::STAT_ONE_SHOT_BIT] = one_shot;
				end
				line_ctrl_pkg::ADDR_THRESH: begin
					st_nxt.rdata = {st_r.thr_high, st_r.thr_low};
				end
				default: begin
					st_nxt.rdata = 32'h0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_r              <= '0;
			st_r.dc_term_mode <= line_ctrl_pkg::DC_RESET;
			st_r.thr_low      <= line_ctrl_pkg::THR_LOW_RESET;
			st_r.thr_high     <= line_ctrl_pkg::THR_HIGH_RESET;
			st_r.tx_gain      <= line_ctrl_pkg::TX_GAIN_UNITY;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign rdata_out                = st_r.rdata;
	assign dc_term_mode_out         = st_r.dc_term_mode;
	assign dc_low_volt_out          = st_r.dc_low_volt;
	assign ac_term_select_out       = st_r.ac_term_select;
	assign ring_thresh_sel_out      = st_r.ring_thresh_sel;
	assign ringer_imp_reduce_out    = st_r.ringer_imp_reduce;
	assign onhook_speed_out         = st_r.onhook_speed;
	assign tx_gain_out              = st_r.tx_gain;
	assign ring_pos_flag_out        = st_r.ring_pos_flag;
	assign ring_neg_flag_out        = st_r.ring_neg_flag;
	assign ring_detect_one_shot_out = one_shot;
endmodule
`default_nettype wire

//--- line_ctrl_props.sv
// line_ctrl_props: port assertions for line_ctrl
// assumes one clock domain, bound into line_ctrl
`timescale 1ns/1ps
`default_nettype none
module line_ctrl_props (
	input wire logic        mclk_in,
	input wire logic        resetn_in,
	input wire logic        rd_in,
	input wire logic        offhook_in,
	input wire logic [31:0] rdata_out,
	input wire logic [1:0]  dc_term_mode_out,
	input wire logic        dc_low_volt_out,
	input wire logic [15:0] tx_gain_out,
	input wire logic        ring_pos_flag_out,
	input wire logic        ring_neg_flag_out,
	input wire logic        ring_detect_one_shot_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);
	sequence s_hook;
		$rose(offhook_in);
	endsequence
	sequence s_shot;
		$rose(ring_detect_one_shot_out);
	endsequence
	a_dc_reset: assert property ($rose(resetn_in) |-> dc_term_mode_out == 2'h2)
		else $error("dc mode not standard after reset");
	a_gain_low: assert property (dc_term_mode_out == 2'h1 |=> tx_gain_out == line_ctrl_pkg::TX_GAIN_LV)
		else $error("tx gain not reduced in low-voltage mode");
	a_gain_unity: assert property (dc_term_mode_out != 2'h1 |=> tx_gain_out == line_ctrl_pkg::TX_GAIN_UNITY)
		else $error("tx gain reduced outside low-voltage mode");
	a_low_modes: assert property (dc_term_mode_out < 2'h2 |=> dc_low_volt_out)
		else $error("low-voltage termination missing");
	a_curlim_mode: assert property (dc_term_mode_out == 2'h3 |=> !dc_low_volt_out)
		else $error("low-voltage termination in current-limit mode");
	a_flags_excl: assert property (!(ring_pos_flag_out && ring_neg_flag_out))
		else $error("both ring flags set");
	a_shot_pos: assert property (s_shot |-> ##[0:2] ring_pos_flag_out)
		else $error("one-shot set without positive excursion");
	a_hook_clear: assert property (s_hook |-> ##[1:6] !ring_detect_one_shot_out)
		else $error("one-shot not cleared by off-hook");
	a_rd_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
		else $error("read data outside read cycle");
endmodule
bind line_ctrl line_ctrl_props u_props (.mclk_in, .resetn_in, .rd_in, .offhook_in, .rdata_out,
	.dc_term_mode_out, .dc_low_volt_out, .tx_gain_out, .ring_pos_flag_out, .ring_neg_flag_out,
	.ring_detect_one_shot_out);
`default_nettype wire

//--- line_model.sv
// line_model: line-side ring sample source
// assumes level_in is the wanted pos-neg difference
`timescale 1ns/1ps
`default_nettype none
module line_model (
	// clock and level
	input  wire logic        mclk_in,
	input  wire logic [15:0] level_in,
	// ring samples
	output logic      [15:0] pos_out,
	output logic      [15:0] neg_out
);
	always_ff @(posedge mclk_in) begin
		pos_out <= 16'h4000 + level_in;
		neg_out <= 16'h4000;
	end
endmodule
`default_nettype wire

//--- tb_line_ctrl.sv
// tb_line_ctrl: self-checking bench for line_ctrl
// assumes line_ctrl_pkg, line_model and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_line_ctrl;
	logic        mclk_in = 1'b0;
	logic        resetn_in = 1'b0;
	logic [7:0]  addr_in = 8'h00;
	logic [31:0] wdata_in = 32'h0;
	logic        wr_in = 1'b0;
	logic        rd_in = 1'b0;
	logic        offhook_in = 1'b0;
	logic [15:0] level = 16'h0;
	logic [31:0] lfsr = 32'hEFBA348D;
	logic [31:0] rdata_out, got, w;
	logic [15:0] ring_in_pos, ring_in_neg, tx_gain_out, thr;
	logic [1:0]  dc_term_mode_out;
	logic        dc_low_volt_out, ac_term_select_out, ring_thresh_sel_out, ringer_imp_reduce_out;
	logic        onhook_speed_out, ring_pos_flag_out, ring_neg_flag_out, ring_detect_one_shot_out;
	int          fail_count = 0;
	int          tests_run = 0;
	int          cycles = 0;
	line_ctrl #(.SAMPLE_DIV(4), .ONE_SHOT(8), .RING_W(16)) dut (.mclk_in, .resetn_in, .addr_in, .wdata_in,
		.wr_in, .rd_in, .rdata_out, .ring_in_pos, .ring_in_neg, .offhook_in, .dc_term_mode_out,
		.dc_low_volt_out, .ac_term_select_out, .ring_thresh_sel_out, .ringer_imp_reduce_out,
		.onhook_speed_out, .tx_gain_out, .ring_pos_flag_out, .ring_neg_flag_out, .ring_detect_one_shot_out);
	line_model line (.mclk_in, .level_in(level), .pos_out(ring_in_pos), .neg_out(ring_in_neg));
	always #2 mclk_in = ~mclk_in;
	always @(posedge mclk_in) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fail_count = fail_count + 1;
			results();
		end
	end
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic exp_lv(input logic [31:0] v);
		return v[3:2] < 2'h2 || (v[3:2] == 2'h2 && v[6]);
	endfunction
	function automatic logic [15:0] exp_gain(input logic [31:0] v);
		return (v[3:2] == 2'h1) ? line_ctrl_pkg::TX_GAIN_LV : line_ctrl_pkg::TX_GAIN_UNITY;
	endfunction
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] act);
		tests_run++;
		if (act !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, act);
		end
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge mclk_in);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge mclk_in);
		wr_in <= 1'b0;
		@(posedge mclk_in);
	endtask
	task automatic rd(input logic [7:0] a);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		@(negedge mclk_in);
		got = rdata_out;
		@(posedge mclk_in);
	endtask
	task automatic step(input logic [15:0] lv, input logic [2:0] exp);
		level <= lv;
		tk(12);
		rd(8'h08);
		chk("ring_status", {29'h0, exp}, got);
	endtask
	task automatic results();
		if (fail_count == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		tk(4);
		resetn_in <= 1'b1;
		tk(1);
		rd(8'h00);
		chk("term_reset", 32'h8, got);
		for (int m = 0; m < 8; m++) begin
			lfsr = lfsr_next(lfsr);
			w = {25'h0, m[2], lfsr[5:4], m[1:0], lfsr[1:0]};
			wr(8'h00, w);
			rd(8'h00);
			chk("term_read", w, got);
			chk("dc_mode", {30'h0, w[3:2]}, dc_term_mode_out);
			chk("low_volt", exp_lv(w), dc_low_volt_out);
			chk("tx_gain", exp_gain(w), tx_gain_out);
			chk("ctrl", w[5:0] & 32'h33, {onhook_speed_out, ac_term_select_out, 2'h0, ringer_imp_reduce_out,
				ring_thresh_sel_out});
		end
		wr(8'h08, 32'hFFFFFFFF);
		wr(8'h10, 32'hFFFFFFFF);
		rd(8'h10);
		chk("unmapped", 32'h0, got);
		rd(8'h08);
		chk("status_ro", 32'h0, got);
		lfsr = lfsr_next(lfsr);
		thr = 16'd100 + lfsr[7:0];
		wr(8'h0C, {16'h1000, thr});
		rd(8'h0C);
		chk("thresh_read", {16'h1000, thr}, got);
		wr(8'h00, 32'h8);
		wr(8'h04, 32'h0);
		step(thr, 3'b000);
		step(thr + 16'd1 + lfsr[16:8], 3'b101);
		step(-thr - 16'd1, 3'b100);
		tk(40);
		rd(8'h08);
		chk("shot_expiry", 32'h0, got);
		wr(8'h04, 32'h1);
		rd(8'h04);
		chk("ring_ctrl_read", 32'h1, got);
		step(-thr - 16'd1, 3'b010);
		step(thr + 16'd1, 3'b101);
		wr(8'h00, 32'h9);
		step(thr + 16'd1, 3'b100);
		step(16'h1001, 3'b101);
		level <= 16'h0;
		tk(8);
		offhook_in <= 1'b1;
		tk(7);
		chk("shot_hook", 32'h0, ring_detect_one_shot_out);
		wr(8'h00, 32'h48);
		tk(1);
		chk("dial_low_volt", 32'h1, dc_low_volt_out);
		chk("dial_gain", line_ctrl_pkg::TX_GAIN_UNITY, tx_gain_out);
		wr(8'h00, 32'h4);
		tk(1);
		chk("restore_gain", line_ctrl_pkg::TX_GAIN_LV, tx_gain_out);
		for (int p = 0; p < 6; p++) begin
			offhook_in <= ~offhook_in;
			tk(10);
			chk("shot_pulse", 32'h0, ring_detect_one_shot_out);
		end
		resetn_in <= 1'b0;
		tk(2);
		resetn_in <= 1'b1;
		tk(1);
		rd(8'h00);
		chk("term_rerst", 32'h8, got);
		chk("gain_rerst", line_ctrl_pkg::TX_GAIN_UNITY, tx_gain_out);
		results();
	end
endmodule
`default_nettype wire
